//--- hdl/fault_sup_consts.svh
// constants of the motor drive fault supervisor: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the design
`ifndef FAULT_SUP_CONSTS_SVH
`define FAULT_SUP_CONSTS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses, word aligned)
// ------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_MASK    8'h08
`define OFS_TIMEOUT     8'h0c
`define OFS_LIMITS      8'h10
`define OFS_SPEED_MAX   8'h14
`define OFS_OUTPUT      8'h18
`define OFS_FEED        8'h1c
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CTRL_OC_LATCH   0
`define CTRL_OT_LATCH   1
`define CTRL_ARM        2
// ------------------------------------------------------------
// status / interrupt fields
// ------------------------------------------------------------
`define ST_OC           0
`define ST_OT           1
`define ST_DERATE       2
`define ST_OVERSPEED    3
`define ST_BRAKE        4
`define ST_REGEN        5
`define ST_TIMEOUT      6
`define ST_WATCHDOG     7
`define ST_WIDTH        8
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CTRL_RESET      32'h0000_0000
`define MASK_RESET      8'h00
`define TIMEOUT_RESET   32'h0000_c350
`define SPEED_MAX_RESET 16'h4000
`define SPEED_EXT_RESET 16'h2000
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_NS          40
`define WDOG_US         1000
`define WDOG_CYCLES     ((`WDOG_US * 1000) / `CLK_NS)
`endif

//--- hdl/fault_sup_pkg.sv
// types of the motor drive fault supervisor
// assumes the constants header beside it
`include "fault_sup_consts.svh"
package fault_sup_pkg;
    typedef enum logic [3:0] {
        BR_DRIVE = 4'b0001,
        BR_OFF   = 4'b0010,
        BR_COAST = 4'b0100,
        BR_BRAKE = 4'b1000
    } bridge_mode_type;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] current_limit;
        logic [15:0] ctl_temp;
        logic [15:0] coil_temp;
        logic [15:0] speed;
        logic [15:0] bus_volt;
    } sense_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;
endpackage

//--- hdl/motor_drive_fault_supervisor.sv
// motor drive fault supervisor: limits, derates, shuts off or brakes the bridge
// assumes sensed values synchronous to sys_clk, one-cycle command strobe
// Behaviour
// - clamp demand to predicted current-safe voltage
// - over-current without extreme over-speed turns every bridge switch off
// - over-current latch selectable, default not latching
// - latched trip holds until host clears
// - non-latching over-current releases below threshold
// - near controller temperature limit, derate output
// - derate ends by itself when cooler
// - estimated coil temperature derates the same way
// - over-temperature without extreme over-speed turns every bridge switch off
// - thermal latch selectable, default not latching
// - above maximum speed, reduce voltage proportionally
// - extreme over-speed shorts all three phases
// - regenerated over-voltage limits applied voltage
// - command timeout disarms and coasts
// - new valid command resumes operation
// - stalled controller forces watchdog reboot
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "fault_sup_consts.svh"

module motor_drive_fault_supervisor #(
    parameter int          WDOG_CYCLES = `WDOG_CYCLES,
    parameter logic [15:0] TEMP_DERATE = 16'h0320,
    parameter logic [15:0] TEMP_TRIP   = 16'h0400,
    parameter logic [15:0] COIL_DERATE = 16'h0640,
    parameter logic [15:0] COIL_TRIP   = 16'h0700,
    parameter logic [15:0] VOLT_MAX    = 16'h0c00
) (
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    input  wire fault_sup_pkg::bus_req_type bus_req,
    output logic [31:0]                   rdata,
    input  wire fault_sup_pkg::sense_type sense,
    input  wire logic [15:0]              demand,
    input  wire logic                     cmd_valid,
    input  wire logic                     core_alive,
    output logic [15:0]                   drive_volt,
    output fault_sup_pkg::bridge_mode_type bridge_mode,
    output logic                          reboot_req,
    output logic                          irq
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // scale x by (256 - k)/256, k saturates at 256
    function automatic logic [15:0] scale_down(input logic [15:0] x, input logic [15:0] k);
        logic [8:0]  f;
        logic [24:0] p;
        f = (k >= 16'h0100) ? 9'h000 : 9'(9'h100 - k[8:0]);
        p = x * f;
        return p[23:8];
    endfunction

    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]            ctrl_r;
    logic [31:0]            timeout_r;
    logic [15:0]            speed_max_r;
    logic [15:0]            speed_ext_r;
    logic [`ST_WIDTH-1:0]   status_r;
    logic [`ST_WIDTH-1:0]   mask_r;
    logic                   wr_ctrl;
    logic                   wr_status;

    assign wr_ctrl   = bus_req.wr && (bus_req.addr == `OFS_CTRL);
    assign wr_status = bus_req.wr && (bus_req.addr == `OFS_STATUS);

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ctrl_r      <= `CTRL_RESET;
            timeout_r   <= `TIMEOUT_RESET;
            speed_max_r <= `SPEED_MAX_RESET;
            speed_ext_r <= `SPEED_EXT_RESET;
            mask_r      <= `MASK_RESET;
        end
        else if (bus_req.wr)
        begin
            unique case (bus_req.addr)
                `OFS_CTRL:      ctrl_r      <= bus_req.wdata;
                `OFS_IRQ_MASK:  mask_r      <= bus_req.wdata[`ST_WIDTH-1:0];
                `OFS_TIMEOUT:   timeout_r   <= bus_req.wdata;
                `OFS_SPEED_MAX:
                begin
                    speed_max_r <= bus_req.wdata[15:0];
                    speed_ext_r <= bus_req.wdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------
    logic oc_now;
    logic ot_now;
    logic derate_now;
    logic ovs_now;
    logic brake_now;
    logic regen_now;
    logic [15:0] ovs_excess;

    assign oc_now     = sense.current >= sense.current_limit;
    assign ot_now     = (sense.ctl_temp >= TEMP_TRIP) || (sense.coil_temp >= COIL_TRIP);
    assign derate_now = (sense.ctl_temp >= TEMP_DERATE)
                     || (sense.coil_temp >= COIL_DERATE);
    assign ovs_now    = sense.speed > speed_max_r;
    assign ovs_excess = ovs_now ? 16'(sense.speed - speed_max_r) : 16'h0000;
    assign brake_now  = ovs_now && (ovs_excess >= speed_ext_r);
    assign regen_now  = sense.bus_volt >= VOLT_MAX;

    // latched trips; set wins over the host clear
    logic oc_lat_r;
    logic ot_lat_r;

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            oc_lat_r <= 1'b0;
            ot_lat_r <= 1'b0;
        end
        else
        begin
            if (oc_now && ctrl_r[`CTRL_OC_LATCH])
                oc_lat_r <= 1'b1;
            else if (wr_status && bus_req.wdata[`ST_OC])
                oc_lat_r <= 1'b0;
            if (ot_now && ctrl_r[`CTRL_OT_LATCH])
                ot_lat_r <= 1'b1;
            else if (wr_status && bus_req.wdata[`ST_OT])
                ot_lat_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // command timeout
    // ------------------------------------------------------------
    logic [31:0] idle_cnt_r;
    logic        timed_out_r;

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            idle_cnt_r  <= 32'h0000_0000;
            timed_out_r <= 1'b0;
        end
        else if (cmd_valid)
        begin
            idle_cnt_r  <= 32'h0000_0000;
            timed_out_r <= 1'b0;
        end
        else if (idle_cnt_r >= timeout_r)
            timed_out_r <= 1'b1;
        else
            idle_cnt_r  <= idle_cnt_r + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // liveness watchdog
    // ------------------------------------------------------------
    logic [31:0] wd_cnt_r;
    logic        wd_fire;

    assign wd_fire = (wd_cnt_r >= 32'(WDOG_CYCLES - 1)) && !core_alive;

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            wd_cnt_r   <= 32'h0000_0000;
            reboot_req <= 1'b0;
        end
        else
        begin
            reboot_req <= wd_fire;
            if (core_alive || wd_fire)
                wd_cnt_r <= 32'h0000_0000;
            else
                wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
        end
    end

    // arm state drops on timeout or reboot; host rearms via control
    logic armed_r;

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            armed_r <= 1'b0;
        else if (wd_fire)
            armed_r <= 1'b0;
        else if (wr_ctrl && bus_req.wdata[`CTRL_ARM])
            armed_r <= 1'b1;
        else if (!timed_out_r && idle_cnt_r >= timeout_r && !cmd_valid)
            armed_r <= 1'b0;
        else if (timed_out_r && cmd_valid)
            armed_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // output voltage and bridge mode
    // ------------------------------------------------------------
    logic [15:0] v_lim;
    fault_sup_pkg::bridge_mode_type mode_nxt;
    logic [15:0] volt_nxt;

    always_comb
    begin
        // predictive ceiling: demand capped at sense.current_limit, used unscaled as a voltage
        v_lim = min16(demand, sense.current_limit);
        if (derate_now)
            v_lim = v_lim >> 1;
        v_lim = scale_down(v_lim, ovs_excess);
        if (regen_now)
            v_lim = v_lim >> 2;
        volt_nxt = v_lim;
        if (brake_now)
            mode_nxt = fault_sup_pkg::BR_BRAKE;
        else if (oc_now || oc_lat_r)
            mode_nxt = fault_sup_pkg::BR_OFF;
        else if (ot_now || ot_lat_r)
            mode_nxt = fault_sup_pkg::BR_OFF;
        else if (!armed_r || timed_out_r)
            mode_nxt = fault_sup_pkg::BR_COAST;
        else
            mode_nxt = fault_sup_pkg::BR_DRIVE;
        if (mode_nxt != fault_sup_pkg::BR_DRIVE)
            volt_nxt = 16'h0000;
    end

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            bridge_mode <= fault_sup_pkg::BR_COAST;
            drive_volt  <= 16'h0000;
        end
        else
        begin
            bridge_mode <= mode_nxt;
            drive_volt  <= volt_nxt;
        end
    end

    // ------------------------------------------------------------
    // sticky status and interrupt
    // ------------------------------------------------------------
    logic [`ST_WIDTH-1:0] events;

    always_comb
    begin
        events = '0;
        events[`ST_OC]        = oc_now;
        events[`ST_OT]        = ot_now;
        events[`ST_DERATE]    = derate_now;
        events[`ST_OVERSPEED] = ovs_now;
        events[`ST_BRAKE]     = brake_now;
        events[`ST_REGEN]     = regen_now;
        events[`ST_TIMEOUT]   = timed_out_r;
        events[`ST_WATCHDOG]  = wd_fire;
    end

    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            status_r <= '0;
        else if (wr_status)
            status_r <= (status_r & ~bus_req.wdata[`ST_WIDTH-1:0]) | events;
        else
            status_r <= status_r | events;
    end

    assign irq = |(status_r & mask_r);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            rdata <= 32'h0000_0000;
        else if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                `OFS_CTRL:      rdata <= {29'h0, armed_r, ctrl_r[1:0]};
                `OFS_STATUS:    rdata <= {24'h0, status_r};
                `OFS_IRQ_MASK:  rdata <= {24'h0, mask_r};
                `OFS_TIMEOUT:   rdata <= timeout_r;
                `OFS_LIMITS:    rdata <= {22'h0, oc_lat_r, ot_lat_r, events};
                `OFS_SPEED_MAX: rdata <= {speed_ext_r, speed_max_r};
                `OFS_OUTPUT:    rdata <= {12'h0, bridge_mode, drive_volt};
                default:        rdata <= 32'h0000_0000;
            endcase
        end
        else
            rdata <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    oc_shutdown_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        oc_now && !brake_now |=> bridge_mode == fault_sup_pkg::BR_OFF)
        else $error("over-current did not switch bridge off");
    oc_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        !oc_now && !oc_lat_r && !ot_now && !ot_lat_r && !brake_now && armed_r && !timed_out_r
        |=> bridge_mode == fault_sup_pkg::BR_DRIVE)
        else $error("bridge not released");
    latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        oc_lat_r && !(wr_status && bus_req.wdata[`ST_OC]) |=> oc_lat_r)
        else $error("latched trip dropped without clear");
    ot_shutdown_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ot_now && !brake_now |=> bridge_mode == fault_sup_pkg::BR_OFF)
        else $error("over-temperature did not switch bridge off");
    brake_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        brake_now |=> bridge_mode == fault_sup_pkg::BR_BRAKE)
        else $error("extreme over-speed not braking");
    volt_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        1'b1 |=> drive_volt <= $past(sense.current_limit))
        else $error("drive voltage above current ceiling");
    timeout_coast_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        timed_out_r && !brake_now && !oc_now && !ot_now && !oc_lat_r && !ot_lat_r
        |=> bridge_mode == fault_sup_pkg::BR_COAST)
        else $error("timeout did not coast");
    resume_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        timed_out_r && cmd_valid |=> !timed_out_r && armed_r)
        else $error("command did not resume");
    wdog_reboot_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        wd_fire |=> reboot_req && !armed_r)
        else $error("watchdog did not reboot");
    sticky_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        status_r[`ST_OC] && !wr_status |=> status_r[`ST_OC])
        else $error("status flag lost");

    oc_trip_c:  cover property (@(posedge sys_clk) disable iff (!rst_n_r) oc_now ##1 !oc_now);
    derate_c:   cover property (@(posedge sys_clk) disable iff (!rst_n_r) derate_now ##1 !derate_now);
    brake_c:    cover property (@(posedge sys_clk) disable iff (!rst_n_r) brake_now);
    timeout_c:  cover property (@(posedge sys_clk) disable iff (!rst_n_r) timed_out_r ##1 cmd_valid);
    // reboot path is reached only with a short watchdog span
    wdog_c:     cover property (@(posedge sys_clk) disable iff (!rst_n_r) wd_fire ##1 reboot_req);

endmodule // motor_drive_fault_supervisor

//--- tb/host_cmd_model.sv
// host model: paces valid command pulses, holds them off after a watchdog reboot until rearm_done
// assumes the bench arms the device over the register port and pulses rearm_done
`timescale 1ns/1ps
module host_cmd_model (
    input  wire logic       sys_clk,
    input  wire logic       enable,
    input  wire logic [7:0] gap,
    input  wire logic       reboot_req,
    input  wire logic       rearm_done,
    output logic            cmd_valid,
    output logic            rearm_needed
);
    logic [7:0] gap_cnt = 8'h00;
    logic       cmd_r   = 1'b0;
    logic       rearm_r = 1'b0;

    assign cmd_valid    = cmd_r;
    assign rearm_needed = rearm_r;

    // after a reboot no drive is expected until arming is redone
    always @(posedge sys_clk)
    begin
        if (reboot_req)
            rearm_r <= 1'b1;
        else if (rearm_done)
            rearm_r <= 1'b0;
    end

    // gap sets a prompt or a slow host
    always @(posedge sys_clk)
    begin
        gap_cnt   <= (gap_cnt >= gap - 8'h01) ? 8'h00 : gap_cnt + 8'h01;
        cmd_r     <= enable && !rearm_r && (gap_cnt == 8'h00);
    end
endmodule // host_cmd_model

//--- tb/tb.sv
// bench for the motor drive fault supervisor: register tasks and protection scenarios
// assumes the design package and constants header on the include path
`timescale 1ns/1ps
`include "fault_sup_consts.svh"
module tb;
    localparam logic [15:0] V_LIM = 16'h0600;
    localparam logic [15:0] C_OK  = 16'h0010;
    localparam logic [15:0] T_OK  = 16'h0100;
    localparam logic [15:0] S_OK  = 16'h1000;
    localparam logic [15:0] B_OK  = 16'h0800;
    logic                           sys_clk      = 1'b0;
    logic                           arst_n       = 1'b0;
    fault_sup_pkg::bus_req_type     bus_req      = '0;
    fault_sup_pkg::sense_type       sense;
    logic [15:0]                    demand       = 16'h0800;
    logic                           core_alive   = 1'b0;
    logic                           alive_en     = 1'b1;
    logic [1:0]                     alive_cnt    = 2'h0;
    logic                           host_en      = 1'b0;
    logic [7:0]                     gap          = 8'h08;
    logic                           rearm_done   = 1'b0;
    logic                           seen         = 1'b0;
    logic [31:0]                    rdata;
    logic [31:0]                    rd_val;
    logic                           cmd_valid;
    logic                           rearm_needed;
    logic [15:0]                    drive_volt;
    fault_sup_pkg::bridge_mode_type bridge_mode;
    logic                           reboot_req;
    logic                           irq;
    int                             mismatches   = 0;
    int                             check_count  = 0;

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        alive_cnt  <= alive_cnt + 2'h1;
        core_alive <= alive_en && (alive_cnt == 2'h0);
    end

    motor_drive_fault_supervisor #(.WDOG_CYCLES(16)) motor_drive_fault_supervisor_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .sense(sense), .demand(demand), .cmd_valid(cmd_valid), .core_alive(core_alive),
        .drive_volt(drive_volt), .bridge_mode(bridge_mode), .reboot_req(reboot_req),
        .irq(irq));

    host_cmd_model host_cmd_model_i (
        .sys_clk(sys_clk), .enable(host_en), .gap(gap), .reboot_req(reboot_req),
        .rearm_done(rearm_done), .cmd_valid(cmd_valid), .rearm_needed(rearm_needed));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        bus_req.addr  <= addr;
        bus_req.wdata <= data;
        bus_req.wr    <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr    <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        bus_req.addr <= addr;
        bus_req.rd   <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd   <= 1'b0;
        #1;
        data = rdata;
    endtask

    task automatic apply(input logic [15:0] cur, ct, cl, spd, bv);
        @(posedge sys_clk);
        sense.current   <= cur;
        sense.ctl_temp  <= ct;
        sense.coil_temp <= cl;
        sense.speed     <= spd;
        sense.bus_volt  <= bv;
    endtask

    // volt only compared where the bridge drives
    task automatic expect_out(input logic [15:0] v, input fault_sup_pkg::bridge_mode_type m,
                              input logic use_v);
        repeat (4) @(posedge sys_clk);
        #1;
        check("bridge_mode", {28'h0, bridge_mode}, {28'h0, m});
        if (use_v)
            check("drive_volt", {16'h0, drive_volt}, {16'h0, v});
    endtask

    task automatic status_bit(input int b);
        bus_read(`OFS_STATUS, rd_val);
        check("status_bit", {31'h0, rd_val[b]}, 32'h1);
    endtask

    // k 0 over-current, 1 over-temperature
    task automatic fault_round(input int k, input logic lat);
        bus_write(`OFS_CTRL, 32'h4 | (32'(lat) << k));
        if (k == 0)
            apply(16'h0800, T_OK, T_OK, S_OK, B_OK);
        else
            apply(C_OK, 16'h0500, T_OK, S_OK, B_OK);
        expect_out(16'h0, fault_sup_pkg::BR_OFF, 1'b0);
        status_bit(k);
        apply(C_OK, T_OK, T_OK, S_OK, B_OK);
        expect_out(V_LIM, lat ? fault_sup_pkg::BR_OFF : fault_sup_pkg::BR_DRIVE, !lat);
        if (lat)
        begin
            bus_read(`OFS_LIMITS, rd_val);
            check("latched", {31'h0, rd_val[9 - k]}, 32'h1);
            bus_write(`OFS_STATUS, 32'h1 << k);
            expect_out(V_LIM, fault_sup_pkg::BR_DRIVE, 1'b1);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        sense = '{current: C_OK, current_limit: V_LIM, ctl_temp: T_OK, coil_temp: T_OK,
                  speed: S_OK, bus_volt: B_OK};
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus_read(`OFS_CTRL, rd_val);
        check("ctrl", rd_val, `CTRL_RESET);
        bus_read(`OFS_IRQ_MASK, rd_val);
        check("mask", rd_val, {24'h0, `MASK_RESET});
        bus_read(`OFS_TIMEOUT, rd_val);
        check("timeout", rd_val, `TIMEOUT_RESET);
        bus_read(`OFS_SPEED_MAX, rd_val);
        check("speed_max", rd_val, {`SPEED_EXT_RESET, `SPEED_MAX_RESET});
        bus_read(8'h20, rd_val);
        check("unmapped", rd_val, 32'h0);
        host_en <= 1'b1;
        bus_write(`OFS_CTRL, 32'h4);
        expect_out(V_LIM, fault_sup_pkg::BR_DRIVE, 1'b1);
        demand <= 16'h0200;
        expect_out(16'h0200, fault_sup_pkg::BR_DRIVE, 1'b1);
        demand <= 16'h0800;
        fault_round(0, 1'b0);
        bus_write(`OFS_IRQ_MASK, 32'h1);
        #1;
        check("irq_set", {31'h0, irq}, 32'h1);
        bus_write(`OFS_IRQ_MASK, 32'h0);
        #1;
        check("irq_masked", {31'h0, irq}, 32'h0);
        bus_write(`OFS_IRQ_MASK, 32'h1);
        bus_write(`OFS_STATUS, 32'h1);
        #1;
        check("irq_clear", {31'h0, irq}, 32'h0);
        fault_round(0, 1'b1);
        fault_round(1, 1'b0);
        fault_round(1, 1'b1);
        apply(C_OK, 16'h0380, T_OK, S_OK, B_OK);
        expect_out(V_LIM >> 1, fault_sup_pkg::BR_DRIVE, 1'b1);
        status_bit(`ST_DERATE);
        apply(C_OK, T_OK, T_OK, S_OK, B_OK);
        expect_out(V_LIM, fault_sup_pkg::BR_DRIVE, 1'b1);
        bus_read(`OFS_OUTPUT, rd_val);
        check("output", rd_val, {12'h0, fault_sup_pkg::BR_DRIVE, V_LIM});
        apply(C_OK, T_OK, 16'h0680, S_OK, B_OK);
        expect_out(V_LIM >> 1, fault_sup_pkg::BR_DRIVE, 1'b1);
        apply(C_OK, T_OK, T_OK, 16'h4040, B_OK);
        expect_out(16'((32'(V_LIM) * 32'h0c0) >> 8), fault_sup_pkg::BR_DRIVE, 1'b1);
        apply(C_OK, T_OK, T_OK, 16'h4080, B_OK);
        expect_out(16'((32'(V_LIM) * 32'h080) >> 8), fault_sup_pkg::BR_DRIVE, 1'b1);
        status_bit(`ST_OVERSPEED);
        apply(C_OK, T_OK, T_OK, 16'h7000, B_OK);
        expect_out(16'h0, fault_sup_pkg::BR_BRAKE, 1'b0);
        status_bit(`ST_BRAKE);
        apply(C_OK, T_OK, T_OK, S_OK, 16'h0d00);
        expect_out(V_LIM >> 2, fault_sup_pkg::BR_DRIVE, 1'b1);
        status_bit(`ST_REGEN);
        apply(C_OK, T_OK, T_OK, S_OK, B_OK);
        bus_write(`OFS_TIMEOUT, 32'h14);
        gap <= 8'h10;
        repeat (60) @(posedge sys_clk);
        expect_out(V_LIM, fault_sup_pkg::BR_DRIVE, 1'b1);
        host_en <= 1'b0;
        repeat (30) @(posedge sys_clk);
        expect_out(16'h0, fault_sup_pkg::BR_COAST, 1'b0);
        status_bit(`ST_TIMEOUT);
        gap <= 8'h08;
        host_en <= 1'b1;
        repeat (12) @(posedge sys_clk);
        expect_out(V_LIM, fault_sup_pkg::BR_DRIVE, 1'b1);
        bus_write(`OFS_TIMEOUT, `TIMEOUT_RESET);
        alive_en <= 1'b0;
        for (int i = 0; i < 80 && !seen; i++)
        begin
            @(posedge sys_clk);
            #1;
            seen = reboot_req;
        end
        check("reboot_req", {31'h0, seen}, 32'h1);
        alive_en <= 1'b1;
        expect_out(16'h0, fault_sup_pkg::BR_COAST, 1'b0);
        check("rearm_needed", {31'h0, rearm_needed}, 32'h1);
        status_bit(`ST_WATCHDOG);
        bus_write(`OFS_CTRL, 32'h4);
        @(posedge sys_clk);
        rearm_done <= 1'b1;
        @(posedge sys_clk);
        rearm_done <= 1'b0;
        repeat (12) @(posedge sys_clk);
        expect_out(V_LIM, fault_sup_pkg::BR_DRIVE, 1'b1);
        conclude();
    end
endmodule // tb
